// >>> spcrs_top.sv
`include "spcrs_defines.svh"
`default_nettype none

module spcrs_top
    import spcrs_pkg::*;
#(
    parameter int RELOAD_W = 8
)
(
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire spcrs_byte_t I_ADDR,
    input wire spcrs_byte_t I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output spcrs_byte_t O_RDATA,
    input wire logic I_BIT7_SEL,
    input wire logic I_DOUBLE_RATE,
    input wire logic I_T1_OVF,
    input wire logic [RELOAD_W-1:0] I_BRG_RELOAD,
    input wire logic I_TX_LAST_BIT,
    input wire logic I_RX_STOP,
    input wire logic I_RX_STOP_BAD,
    input wire logic I_RX_NINTH,
    output spcrs_mode_t O_MODE,
    output logic O_ADDR_RECOG_EN,
    output logic O_RX_ENABLE,
    output logic O_TX_ENABLE,
    output logic O_TX_NINTH,
    output logic O_TX_BIT_TICK,
    output logic O_RX_BIT_TICK,
    output logic O_IRQ
);
    // serial_control storage
    logic ferr_q;
    logic ferr_d;
    logic mhi_q;
    logic mhi_d;
    logic mlo_q;
    logic mlo_d;
    logic mpc_q;
    logic mpc_d;
    logic ren_q;
    logic ren_d;
    logic txn_q;
    logic txn_d;
    logic rxn_q;
    logic rxn_d;
    logic txd_q;
    logic txd_d;
    logic rxd_q;
    logic rxd_d;
    // baud_rate_control, interrupt and bus storage
    logic [`SPCRS_BR_USED_W-1:0] bdr_q;
    logic [`SPCRS_BR_USED_W-1:0] bdr_d;
    logic [`SPCRS_IRQ_W-1:0] stat_q;
    logic [`SPCRS_IRQ_W-1:0] stat_d;
    logic [`SPCRS_IRQ_W-1:0] mask_q;
    logic [`SPCRS_IRQ_W-1:0] mask_d;
    logic rx_en_q;
    logic tx_en_q;
    logic tx_ninth_q;
    spcrs_byte_t rdata_q;
    logic brg_tick;

    // address decode
    wire wr_serial_control_w = I_WR && (I_ADDR == `SPCRS_ADDR_SER_CTRL);
    wire wr_bdr_w = I_WR && (I_ADDR == `SPCRS_ADDR_RATE_CTRL);
    wire wr_stat_w = I_WR && (I_ADDR == `SPCRS_ADDR_IRQ_STAT);
    wire wr_mask_w = I_WR && (I_ADDR == `SPCRS_ADDR_IRQ_MASK);
    wire wr_ferr_w = wr_serial_control_w && I_BIT7_SEL;
    wire wr_mhi_w = wr_serial_control_w && !I_BIT7_SEL;

    // frame events from the shift engine
    wire ferr_set_w = I_RX_STOP && I_RX_STOP_BAD;

    // flag updates: a hardware set in the same cycle beats a software clear
    assign ferr_d = ferr_set_w || (wr_ferr_w ? I_WDATA[`SPCRS_SC_BIT7] : ferr_q);
    assign mhi_d = wr_mhi_w ? I_WDATA[`SPCRS_SC_BIT7] : mhi_q;
    assign mlo_d = wr_serial_control_w ? I_WDATA[`SPCRS_SC_MODE_LOW] : mlo_q;
    assign mpc_d = wr_serial_control_w ? I_WDATA[`SPCRS_SC_MULTIPROC] : mpc_q;
    assign ren_d = wr_serial_control_w ? I_WDATA[`SPCRS_SC_RX_EN] : ren_q;
    assign txn_d = wr_serial_control_w ? I_WDATA[`SPCRS_SC_TX_NINTH] : txn_q;
    assign rxn_d = I_RX_STOP ? I_RX_NINTH : (wr_serial_control_w ? I_WDATA[`SPCRS_SC_RX_NINTH] : rxn_q);
    assign txd_d = I_TX_LAST_BIT || (wr_serial_control_w ? I_WDATA[`SPCRS_SC_TX_DONE] : txd_q);
    assign rxd_d = I_RX_STOP || (wr_serial_control_w ? I_WDATA[`SPCRS_SC_RX_DONE] : rxd_q);

    // reserved bits of baud_rate_control are not stored and read as zero
    assign bdr_d = wr_bdr_w ? I_WDATA[`SPCRS_BR_USED_W-1:0] : bdr_q;

    // interrupt status: write one to clear, a new event wins the race
    wire [`SPCRS_IRQ_W-1:0] stat_set_w = {ferr_set_w, I_TX_LAST_BIT, I_RX_STOP};
    wire [`SPCRS_IRQ_W-1:0] stat_clr_w = wr_stat_w ? I_WDATA[`SPCRS_IRQ_W-1:0] : 3'h0;
    assign stat_d = stat_set_w | (stat_q & ~stat_clr_w);
    assign mask_d = wr_mask_w ? I_WDATA[`SPCRS_IRQ_W-1:0] : mask_q;

    // gating by mode, computed from next values so outputs track the registers
    wire [1:0] mode_d_w = {mhi_d, mlo_d};
    wire mode0_d_w = (mode_d_w == 2'h0);
    wire rx_en_d_w = ren_d && !mode0_d_w;
    wire tx_en_d_w = !mode0_d_w || ren_d;
    wire tx_ninth_d_w = txn_d && mode_d_w[1];

    // read mux; bit 7 view follows the select input at the time of the read
    wire bit7_w = I_BIT7_SEL ? ferr_q : mhi_q;
    wire [7:0] serial_control_rd_w = {bit7_w, mlo_q, mpc_q, ren_q, txn_q, rxn_q, txd_q, rxd_q};
    wire [7:0] bdr_rd_w = {3'h0, bdr_q};
    wire [7:0] stat_rd_w = {5'h00, stat_q};
    wire [7:0] mask_rd_w = {5'h00, mask_q};
    wire [7:0] rd_val_w = (I_ADDR == `SPCRS_ADDR_SER_CTRL) ? serial_control_rd_w :
                          (I_ADDR == `SPCRS_ADDR_RATE_CTRL) ? bdr_rd_w :
                          (I_ADDR == `SPCRS_ADDR_IRQ_STAT) ? stat_rd_w :
                          (I_ADDR == `SPCRS_ADDR_IRQ_MASK) ? mask_rd_w : 8'h00;

    // serial_control flops
    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RESETN)
        begin
            {ferr_q, mhi_q, mlo_q, mpc_q, ren_q, txn_q, rxn_q, txd_q, rxd_q} <= 9'h000;
        end
        else
        begin
            {ferr_q, mhi_q, mlo_q, mpc_q} <= {ferr_d, mhi_d, mlo_d, mpc_d};
            {ren_q, txn_q, rxn_q, txd_q, rxd_q} <= {ren_d, txn_d, rxn_d, txd_d, rxd_d};
        end
    end

    // control, interrupt and read-back flops
    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RESETN)
        begin
            bdr_q <= `SPCRS_RST_BDR;
            stat_q <= `SPCRS_RST_IRQ;
            mask_q <= `SPCRS_RST_IRQ;
            {rx_en_q, tx_en_q, tx_ninth_q, O_IRQ} <= 4'h0;
            rdata_q <= `SPCRS_RST_BYTE;
        end
        else
        begin
            bdr_q <= bdr_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            {rx_en_q, tx_en_q, tx_ninth_q} <= {rx_en_d_w, tx_en_d_w, tx_ninth_d_w};
            O_IRQ <= |(stat_d & mask_d);
            rdata_q <= I_RD ? rd_val_w : 8'h00; // data stand only in the cycle after
        end
    end

    assign O_RDATA = rdata_q;
    assign O_MODE = {mhi_q, mlo_q};
    assign O_ADDR_RECOG_EN = mpc_q;
    assign O_RX_ENABLE = rx_en_q;
    assign O_TX_ENABLE = tx_en_q;
    assign O_TX_NINTH = tx_ninth_q;

    // rate selection per direction; modes 1 and 3 pick a source
    wire mode0_w = (O_MODE == 2'h0);
    wire mode2_w = (O_MODE == 2'h2);
    wire tx_src_w = bdr_q[`SPCRS_BR_TX_SRC] ? brg_tick : I_T1_OVF;
    wire rx_src_w = bdr_q[`SPCRS_BR_RX_SRC] ? brg_tick : I_T1_OVF;
    // mode 2 and mode 0 divide the peripheral clock itself
    wire tx_tick_in_w = (mode0_w || mode2_w) ? 1'b1 : tx_src_w;
    wire rx_tick_in_w = (mode0_w || mode2_w) ? 1'b1 : rx_src_w;
    wire [5:0] div_w = mode0_w ? `SPCRS_DIV_MODE0 :
                       (I_DOUBLE_RATE ? `SPCRS_DIV_DOUBLE : `SPCRS_DIV_NORMAL);

    // internal generator shared by both directions
    spcrs_brg #(
        .RELOAD_W(RELOAD_W)
    ) u_brg (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RESETN),
        .i_run(bdr_q[`SPCRS_BR_RUN]),
        .i_fast(bdr_q[`SPCRS_BR_FAST]),
        .i_clk_src(bdr_q[`SPCRS_BR_CLK_SRC]),
        .i_reload(I_BRG_RELOAD),
        .o_tick(brg_tick)
    );

    // separate dividers so transmit and receive rates may differ
    spcrs_rate_div u_tx_div (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RESETN),
        .i_tick(tx_tick_in_w),
        .i_div(div_w),
        .o_tick(O_TX_BIT_TICK)
    );

    spcrs_rate_div u_rx_div (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RESETN),
        .i_tick(rx_tick_in_w),
        .i_div(div_w),
        .o_tick(O_RX_BIT_TICK)
    );

    // elaboration check: the reload value is one byte wide
    if (RELOAD_W != 8)
    begin : g_reload_chk
        $error("reload width must be 8 for this register map");
    end

    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RESETN);

    property p_ferr_set;
        (I_RX_STOP && I_RX_STOP_BAD) |=> ferr_q ##1 (ferr_q || $past(wr_ferr_w));
    endproperty
    a_ferr_set: assert property (p_ferr_set) else $error("framing error not set");

    property p_ferr_hold;
        (ferr_q && !wr_ferr_w) |=> ferr_q;
    endproperty
    a_ferr_hold: assert property (p_ferr_hold) else $error("framing error lost");

    property p_bit7_view;
        (I_RD && I_ADDR == `SPCRS_ADDR_SER_CTRL)
            |=> O_RDATA[7] == ($past(I_BIT7_SEL) ? $past(ferr_q) : $past(mhi_q));
    endproperty
    a_bit7_view: assert property (p_bit7_view) else $error("bit 7 view wrong");

    property p_mode_write;
        wr_serial_control_w |=> O_MODE[0] == $past(I_WDATA[6]) ##0 O_ADDR_RECOG_EN == $past(I_WDATA[5]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost");

    property p_rx_gate;
        O_RX_ENABLE |-> (ren_q && O_MODE != 2'h0);
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("reception not gated");

    property p_tx_gate;
        (O_MODE == 2'h0 && !ren_q) |-> !O_TX_ENABLE;
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("mode 0 transmit not gated");

    property p_ninth;
        O_TX_NINTH == (txn_q && O_MODE[1]);
    endproperty
    a_ninth: assert property (p_ninth) else $error("ninth bit wrong");

    property p_tx_done;
        I_TX_LAST_BIT |=> txd_q;
    endproperty
    a_tx_done: assert property (p_tx_done) else $error("transmit done not set");

    property p_rx_done;
        I_RX_STOP |=> rxd_q && rxn_q == $past(I_RX_NINTH);
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("receive done not set");

    property p_mode2_rate;
        (mode2_w && !I_DOUBLE_RATE && O_TX_BIT_TICK) ##1 (mode2_w && !I_DOUBLE_RATE)[*8]
            |-> !$past(O_TX_BIT_TICK);
    endproperty
    a_mode2_rate: assert property (p_mode2_rate) else $error("mode 2 rate too fast");

    c_frame_err: cover property (I_RX_STOP && I_RX_STOP_BAD);
    c_irq: cover property (O_IRQ);
    c_brg_tx: cover property (bdr_q[`SPCRS_BR_TX_SRC] && brg_tick);
    c_mode2_tick: cover property (mode2_w && O_RX_BIT_TICK);
endmodule : spcrs_top

`default_nettype wire

// >>> spcrs_defines.svh
`ifndef SPCRS_DEFINES_SVH
`define SPCRS_DEFINES_SVH

// register byte addresses on the plain register port
`define SPCRS_ADDR_SER_CTRL 8'h98
`define SPCRS_ADDR_RATE_CTRL 8'h9B
`define SPCRS_ADDR_IRQ_STAT 8'h9C
`define SPCRS_ADDR_IRQ_MASK 8'h9D

// serial_control field positions
`define SPCRS_SC_BIT7 7
`define SPCRS_SC_MODE_LOW 6
`define SPCRS_SC_MULTIPROC 5
`define SPCRS_SC_RX_EN 4
`define SPCRS_SC_TX_NINTH 3
`define SPCRS_SC_RX_NINTH 2
`define SPCRS_SC_TX_DONE 1
`define SPCRS_SC_RX_DONE 0

// baud_rate_control field positions
`define SPCRS_BR_RUN 4
`define SPCRS_BR_TX_SRC 3
`define SPCRS_BR_RX_SRC 2
`define SPCRS_BR_FAST 1
`define SPCRS_BR_CLK_SRC 0
`define SPCRS_BR_USED_W 5

// interrupt status and mask field positions
`define SPCRS_IRQ_RX_DONE 0
`define SPCRS_IRQ_TX_DONE 1
`define SPCRS_IRQ_FRAME_ERR 2
`define SPCRS_IRQ_W 3

// reset values
`define SPCRS_RST_BYTE 8'h00
`define SPCRS_RST_BDR 5'h00
`define SPCRS_RST_IRQ 3'h0

// rate divisors, in source ticks per bit
`define SPCRS_DIV_NORMAL 6'h20
`define SPCRS_DIV_DOUBLE 6'h10
`define SPCRS_DIV_MODE0 6'h0C
// prescale of the generator in slow form, and for the oscillator source
`define SPCRS_BRG_SLOW_PRE 3'h6
`define SPCRS_BRG_FAST_PRE 3'h1

`endif

// >>> spcrs_pkg.sv
`default_nettype none

package spcrs_pkg;
    typedef logic [7:0] spcrs_byte_t;
    typedef logic [5:0] spcrs_div_t;
    typedef logic [1:0] spcrs_mode_t;
endpackage : spcrs_pkg

`default_nettype wire

// >>> spcrs_rate_div.sv
`include "spcrs_defines.svh"
`default_nettype none

module spcrs_rate_div
    import spcrs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_tick,
    input wire spcrs_div_t i_div,
    output logic o_tick
);
    spcrs_div_t cnt_q;
    spcrs_div_t cnt_d;
    logic tick_d;
    wire last_w = (cnt_q >= (i_div - 6'h01));

    // counts source ticks; a shrinking divisor wraps at once, never hangs
    assign tick_d = i_tick && last_w;
    assign cnt_d = !i_tick ? cnt_q : (last_w ? 6'h00 : cnt_q + 6'h01);

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            cnt_q <= 6'h00;
            o_tick <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            o_tick <= tick_d;
        end
    end

    // elaboration check: the largest divisor must fit the counter
    if (`SPCRS_DIV_NORMAL > 6'h3F)
    begin : g_div_chk
        $error("divisor does not fit the counter");
    end
endmodule : spcrs_rate_div

`default_nettype wire

// >>> spcrs_brg.sv
`include "spcrs_defines.svh"
`default_nettype none

module spcrs_brg
    import spcrs_pkg::*;
#(
    parameter int RELOAD_W = 8
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_run,
    input wire logic i_fast,
    input wire logic i_clk_src,
    input wire logic [RELOAD_W-1:0] i_reload,
    output logic o_tick
);
    logic [2:0] pre_q;
    logic [2:0] pre_d;
    logic [RELOAD_W-1:0] cnt_q;
    logic [RELOAD_W-1:0] cnt_d;
    logic run_q;
    wire [2:0] pre_max_w;
    wire pre_tick_w;
    wire wrap_w;

    // fast form only when the peripheral clock is the source
    assign pre_max_w = (i_clk_src && i_fast) ? `SPCRS_BRG_FAST_PRE : `SPCRS_BRG_SLOW_PRE;
    assign pre_tick_w = (pre_q >= (pre_max_w - 3'h1));
    assign wrap_w = pre_tick_w && (&cnt_q);

    // stopped generator holds at reload, so a start counts a full period
    assign pre_d = (!i_run || pre_tick_w) ? 3'h0 : pre_q + 3'h1;
    assign cnt_d = (!i_run || !run_q || wrap_w) ? i_reload :
                   (pre_tick_w ? cnt_q + 1'b1 : cnt_q);

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            pre_q <= 3'h0;
            cnt_q <= '0;
            run_q <= 1'b0;
            o_tick <= 1'b0;
        end
        else
        begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            run_q <= i_run;
            o_tick <= i_run && run_q && wrap_w;
        end
    end

    // elaboration check on the reload width
    if (RELOAD_W < 1 || RELOAD_W > 16)
    begin : g_reload_chk
        $error("reload width out of range");
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    property p_brg_stopped;
        !i_run |=> !o_tick;
    endproperty
    a_brg_stopped: assert property (p_brg_stopped) else $error("tick while stopped");

    property p_brg_start;
        $rose(i_run) |=> (cnt_q == $past(i_reload));
    endproperty
    a_brg_start: assert property (p_brg_start) else $error("start not from reload");

    property p_brg_slow;
        (o_tick && !i_fast && $past(!i_fast)) ##1 !i_fast[*5] |-> !$past(o_tick);
    endproperty
    a_brg_slow: assert property (p_brg_slow) else $error("slow form too fast");

    c_brg_tick: cover property (i_run && o_tick);
endmodule : spcrs_brg

`default_nettype wire

// >>> spcrs_peer.sv
`default_nettype none

module spcrs_peer
#(
    parameter int T1_PER = 4
)
(
    input wire logic i_clk,
    input wire logic i_rx_go,
    input wire logic i_tx_go,
    input wire logic i_bad,
    input wire logic i_ninth,
    output logic o_rx_stop,
    output logic o_tx_last,
    output logic o_bad,
    output logic o_ninth,
    output logic o_t1_ovf
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    // defined levels from time zero
    initial
    begin
        o_rx_stop = 1'b0;
        o_tx_last = 1'b0;
        o_bad = 1'b0;
        o_ninth = 1'b0;
        o_t1_ovf = 1'b0;
    end
    // qualifiers toggle outside frames so a stale value is never trusted
    always @(posedge i_clk)
    begin
        o_rx_stop <= i_rx_go;
        o_tx_last <= i_tx_go;
        o_bad <= i_rx_go ? i_bad : ~o_bad;
        o_ninth <= i_rx_go ? i_ninth : ~o_ninth;
        cnt <= (cnt == T1_PER - 1) ? 0 : cnt + 1;
        o_t1_ovf <= (cnt == 0);
    end
endmodule : spcrs_peer

`default_nettype wire

// >>> spcrs_tb_top.sv
`include "spcrs_defines.svh"
`default_nettype none

module spcrs_tb_top;
    import spcrs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic w_stb = 1'b0, r_stb = 1'b0, sel = 1'b0, dbl = 1'b0;
    logic rx_go = 1'b0, tx_go = 1'b0, bad = 1'b0, ninth = 1'b0;
    spcrs_byte_t addr = 8'h00, wdata = 8'h00, rdata;
    logic [7:0] reload = 8'hFE;
    logic rx_stop, tx_last, stop_bad, rx_nin, t1_ovf, recog, rx_en, tx_en;
    logic tx_nin, txt, rxt, irq;
    spcrs_mode_t mode;
    int mismatches = 0, checks = 0, g, i;
    logic [31:0] seed = 32'hD7053FFB;
    logic [7:0] v, r;

    spcrs_top DUT (.I_REF_CLK(clk), .I_RESETN(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(w_stb), .I_RD(r_stb), .O_RDATA(rdata), .I_BIT7_SEL(sel),
        .I_DOUBLE_RATE(dbl), .I_T1_OVF(t1_ovf), .I_BRG_RELOAD(reload),
        .I_TX_LAST_BIT(tx_last), .I_RX_STOP(rx_stop), .I_RX_STOP_BAD(stop_bad),
        .I_RX_NINTH(rx_nin), .O_MODE(mode), .O_ADDR_RECOG_EN(recog),
        .O_RX_ENABLE(rx_en), .O_TX_ENABLE(tx_en), .O_TX_NINTH(tx_nin),
        .O_TX_BIT_TICK(txt), .O_RX_BIT_TICK(rxt), .O_IRQ(irq));
    spcrs_peer #(.T1_PER(4)) peer (.i_clk(clk), .i_rx_go(rx_go), .i_tx_go(tx_go),
        .i_bad(bad), .i_ninth(ninth), .o_rx_stop(rx_stop), .o_tx_last(tx_last),
        .o_bad(stop_bad), .o_ninth(rx_nin), .o_t1_ovf(t1_ovf));

    // 20 MHz reference
    initial
    begin
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // expected port image of a serial_control write
    function automatic logic [7:0] exp_ports(input logic [7:0] d);
        logic [1:0] m;
        m = d[7:6];
        return {m, d[5], d[4] & (m != 2'h0), (m != 2'h0) | d[4], d[3] & m[1], 2'h0};
    endfunction : exp_ports

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task print_verdict();
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        w_stb <= 1'b1;
        @(posedge clk);
        w_stb <= 1'b0;
        #1;
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        r_stb <= 1'b1;
        @(posedge clk);
        r_stb <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    // one frame event from the peer, then let the flags settle
    task frame(input logic is_rx, input logic b, input logic nb);
        @(posedge clk);
        rx_go <= is_rx;
        tx_go <= ~is_rx;
        bad <= b;
        ninth <= nb;
        @(posedge clk);
        rx_go <= 1'b0;
        tx_go <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : frame

    // distance between two bit ticks, -1 when none come
    task rate(input logic [7:0] sc, input logic [7:0] bd, input logic dr,
              input logic use_rx, input int e);
        int k, t0, p;
        dbl <= dr;
        wr(`SPCRS_ADDR_SER_CTRL, sc);
        wr(`SPCRS_ADDR_RATE_CTRL, bd);
        t0 = -1;
        p = -1;
        for (k = 0; k < 4000 && p < 0; k++)
        begin
            @(posedge clk);
            #1;
            if (use_rx ? rxt : txt)
            begin
                if (t0 >= 0)
                    p = k - t0;
                t0 = k;
            end
        end
        chk(p, e);
    endtask : rate

    // hang guard well above the cycle budget
    initial
    begin
        #5000000;
        mismatches++;
        print_verdict();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, plus an unmapped place
        rd(`SPCRS_ADDR_SER_CTRL, v);
        chk(v, 8'h00);
        rd(`SPCRS_ADDR_RATE_CTRL, v);
        chk(v, 8'h00);
        rd(`SPCRS_ADDR_IRQ_STAT, v);
        chk(v, 8'h00);
        rd(8'h00, v);
        chk(v, 8'h00);
        // reserved bits are written as zero
        r = rnd();
        wr(`SPCRS_ADDR_RATE_CTRL, {3'h0, r[4:0]});
        rd(`SPCRS_ADDR_RATE_CTRL, v);
        chk(v, {3'h0, r[4:0]});
        // every mode with receive enable both ways, bits 5 and 3 random, flag bits zero
        for (i = 0; i < 8; i++)
        begin
            r = rnd();
            v = {i[1:0], r[5], i[2], r[3], 3'h0};
            wr(`SPCRS_ADDR_SER_CTRL, v);
            chk({mode, recog, rx_en, tx_en, tx_nin, 2'h0}, exp_ports(v));
            rd(`SPCRS_ADDR_SER_CTRL, r);
            chk(r, v);
        end
        // flags, sticky framing error and interrupt path
        wr(`SPCRS_ADDR_IRQ_MASK, 8'h07);
        wr(`SPCRS_ADDR_SER_CTRL, 8'h40);
        sel <= 1'b1;
        frame(1'b1, 1'b1, 1'b1);
        rd(`SPCRS_ADDR_SER_CTRL, v);
        chk(v, 8'hC5);
        chk(irq, 1'b1);
        frame(1'b1, 1'b0, 1'b0);
        rd(`SPCRS_ADDR_SER_CTRL, v);
        chk(v, 8'hC1);
        rd(`SPCRS_ADDR_IRQ_STAT, v);
        chk(v, 8'h05);
        wr(`SPCRS_ADDR_IRQ_STAT, 8'h07);
        chk(irq, 1'b0);
        frame(1'b0, 1'b0, 1'b0);
        rd(`SPCRS_ADDR_SER_CTRL, v);
        chk(v, 8'hC3);
        chk(irq, 1'b1);
        wr(`SPCRS_ADDR_IRQ_MASK, 8'h00);
        chk(irq, 1'b0);
        wr(`SPCRS_ADDR_SER_CTRL, 8'h40);
        rd(`SPCRS_ADDR_SER_CTRL, v);
        chk(v, 8'h40);
        sel <= 1'b0;
        // bit rates; generator reload drawn from F0..FE
        g = 16 - (rnd() % 15);
        reload <= 8'(256 - g);
        rate(8'h90, 8'h00, 1'b0, 1'b0, 32);
        rate(8'h90, 8'h00, 1'b1, 1'b0, 16);
        rate(8'h10, 8'h00, 1'b0, 1'b0, 12);
        rate(8'h50, 8'h1B, 1'b1, 1'b0, 16 * g);
        rate(8'h50, 8'h1B, 1'b1, 1'b1, 64);
        rate(8'h50, 8'h19, 1'b1, 1'b0, 96 * g);
        rate(8'h50, 8'h1A, 1'b1, 1'b0, 96 * g);
        rate(8'h50, 8'h17, 1'b0, 1'b1, 32 * g);
        rate(8'h50, 8'h17, 1'b0, 1'b0, 128);
        rate(8'h50, 8'h0B, 1'b1, 1'b0, -1);
        print_verdict();
    end
endmodule : spcrs_tb_top

`default_nettype wire
